// *** core/pulse_timing_defines.svh ***
`ifndef PULSE_TIMING_DEFINES_SVH
`define PULSE_TIMING_DEFINES_SVH

// ****************************************************************
// time base
// ****************************************************************
// one lsb of every time value held by the block, in ns
`define PW_UNIT_NS          10
// core clock period in ns (20 MHz)
`define PW_CLK_PERIOD_NS    50
// ns in one second, us and ms, as 64-bit figures for exact scaling
`define PW_NS_PER_S         64'd1000000000
`define PW_NS_PER_MS        64'd1000000
`define PW_NS_PER_US        64'd1000

// ****************************************************************
// period limits and default
// ****************************************************************
`define PW_PERIOD_MIN_NS    200
`define PW_PERIOD_MAX_S     2000
`define PW_PERIOD_DEF_MS    1

// ****************************************************************
// width limits and default
// ****************************************************************
`define PW_WIDTH_MIN_NS     40
`define PW_WIDTH_DEF_US     500

// ****************************************************************
// period bands and their minimum width
// ****************************************************************
`define PW_BAND1_S          10
`define PW_BAND2_S          100
`define PW_BAND3_S          1000
`define PW_WMIN1_NS         40
`define PW_WMIN2_NS         200
`define PW_WMIN3_US         2
`define PW_WMIN4_US         20

// ****************************************************************
// duty cycle, in hundredths of a percent
// ****************************************************************
`define PW_DUTY_FULL        10000
`define PW_DUTY_DEF         5000

`endif

// *** core/pulse_timing_pkg.sv ***
package pulse_timing_pkg;

    // time values in 10 ns steps: 2000 s needs 38 bits
    typedef logic [37:0] ptime_t;
    // duty in hundredths of a percent, 0 to 9999
    typedef logic [13:0] duty_t;

    // which setting a host command writes
    typedef enum logic [1:0]
    {
        SEL_PERIOD,
        SEL_WIDTH,
        SEL_DUTY
    } cmd_sel_e;

    // update sequencer
    typedef enum logic [1:0]
    {
        ST_IDLE,
        ST_WIDTH_DIV,
        ST_DUTY_DIV
    } upd_state_e;

endpackage

// *** core/seq_divider.sv ***
`timescale 1ns/1ns

// restoring divider, one quotient bit per clock
module seq_divider
#(
    parameter int DIVIDEND_W = 52,
    parameter int DIVISOR_W  = 38
)
(
    // clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst_n,
    // request
    input  wire logic                  i_start,
    input  wire logic [DIVIDEND_W-1:0] i_dividend,
    input  wire logic [DIVISOR_W-1:0]  i_divisor,
    // answer
    output logic                       o_done,
    output logic [DIVIDEND_W-1:0]      o_quotient
);

    localparam int CNT_W = $clog2(DIVIDEND_W + 1);

    logic [DIVISOR_W:0]    rem_ff;
    logic [DIVISOR_W:0]    nxt_rem;
    logic [DIVIDEND_W-1:0] quo_ff;
    logic [DIVIDEND_W-1:0] nxt_quo;
    logic [DIVISOR_W-1:0]  divr_ff;
    logic [DIVISOR_W-1:0]  nxt_divr;
    logic [CNT_W-1:0]      cnt_ff;
    logic [CNT_W-1:0]      nxt_cnt;
    logic                  busy_ff;
    logic                  nxt_busy;
    logic                  done_ff;
    logic                  nxt_done;
    logic [DIVISOR_W:0]    rem_shift;

    // a start is honoured only while idle; the caller never overlaps requests
    always_comb
    begin
        nxt_rem   = rem_ff;
        nxt_quo   = quo_ff;
        nxt_divr  = divr_ff;
        nxt_cnt   = cnt_ff;
        nxt_busy  = busy_ff;
        nxt_done  = 1'b0;
        rem_shift = {rem_ff[DIVISOR_W-1:0], quo_ff[DIVIDEND_W-1]};
        if (busy_ff)
        begin
            if (rem_shift >= {1'b0, divr_ff})
            begin
                nxt_rem = rem_shift - {1'b0, divr_ff};
                nxt_quo = {quo_ff[DIVIDEND_W-2:0], 1'b1};
            end
            else
            begin
                nxt_rem = rem_shift;
                nxt_quo = {quo_ff[DIVIDEND_W-2:0], 1'b0};
            end
            nxt_cnt = cnt_ff - 1'b1;
            if (cnt_ff == CNT_W'(1))
            begin
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
            end
        end
        else if (i_start)
        begin
            nxt_rem  = '0;
            nxt_quo  = i_dividend;
            nxt_divr = i_divisor;
            nxt_cnt  = CNT_W'(DIVIDEND_W);
            nxt_busy = 1'b1;
        end
    end

    // registers only
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rem_ff  <= '0;
            quo_ff  <= '0;
            divr_ff <= '0;
            cnt_ff  <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else
        begin
            rem_ff  <= nxt_rem;
            quo_ff  <= nxt_quo;
            divr_ff <= nxt_divr;
            cnt_ff  <= nxt_cnt;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
        end
    end

    assign o_done     = done_ff;
    assign o_quotient = quo_ff;

endmodule

// *** core/pulse_waveform_timing.sv ***
`timescale 1ns/1ns
`include "pulse_timing_defines.svh"

module pulse_waveform_timing
    import pulse_timing_pkg::*;
#(
    parameter int TIME_W = 38,
    parameter int DUTY_W = 14
)
(
    // clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_n,
    // host command port
    input  wire logic              i_cmd_valid,
    input  wire logic [1:0]        i_cmd_sel,
    input  wire logic [TIME_W-1:0] i_cmd_value,
    output logic                   o_cmd_ready,
    output logic                   o_cmd_reject,
    // settings in force
    output logic [TIME_W-1:0]      o_period,
    output logic [TIME_W-1:0]      o_width,
    output logic [DUTY_W-1:0]      o_duty,
    output logic [TIME_W-1:0]      o_min_width,
    // generated waveform
    output logic                   o_pulse
);

    // ****************************************************************
    // constants in time steps
    // ****************************************************************
    localparam int PROD_W = TIME_W + DUTY_W;

    localparam logic [TIME_W-1:0] PERIOD_MIN =
        TIME_W'(`PW_PERIOD_MIN_NS / `PW_UNIT_NS);
    localparam logic [TIME_W-1:0] PERIOD_MAX =
        TIME_W'(`PW_NS_PER_S * `PW_PERIOD_MAX_S / `PW_UNIT_NS);
    localparam logic [TIME_W-1:0] PERIOD_DEF =
        TIME_W'(`PW_NS_PER_MS * `PW_PERIOD_DEF_MS / `PW_UNIT_NS);
    localparam logic [TIME_W-1:0] WIDTH_MIN =
        TIME_W'(`PW_WIDTH_MIN_NS / `PW_UNIT_NS);
    localparam logic [TIME_W-1:0] WIDTH_DEF =
        TIME_W'(`PW_NS_PER_US * `PW_WIDTH_DEF_US / `PW_UNIT_NS);
    localparam logic [TIME_W-1:0] BAND1 =
        TIME_W'(`PW_NS_PER_S * `PW_BAND1_S / `PW_UNIT_NS);
    localparam logic [TIME_W-1:0] BAND2 =
        TIME_W'(`PW_NS_PER_S * `PW_BAND2_S / `PW_UNIT_NS);
    localparam logic [TIME_W-1:0] BAND3 =
        TIME_W'(`PW_NS_PER_S * `PW_BAND3_S / `PW_UNIT_NS);
    localparam logic [TIME_W-1:0] WMIN1 =
        TIME_W'(`PW_WMIN1_NS / `PW_UNIT_NS);
    localparam logic [TIME_W-1:0] WMIN2 =
        TIME_W'(`PW_WMIN2_NS / `PW_UNIT_NS);
    localparam logic [TIME_W-1:0] WMIN3 =
        TIME_W'(`PW_NS_PER_US * `PW_WMIN3_US / `PW_UNIT_NS);
    localparam logic [TIME_W-1:0] WMIN4 =
        TIME_W'(`PW_NS_PER_US * `PW_WMIN4_US / `PW_UNIT_NS);
    localparam logic [DUTY_W-1:0] DUTY_FULL = DUTY_W'(`PW_DUTY_FULL);
    localparam logic [DUTY_W-1:0] DUTY_DEF  = DUTY_W'(`PW_DUTY_DEF);
    // phase advance per clock; 40 ns widths round to the 50 ns grid
    localparam logic [TIME_W-1:0] STEP =
        TIME_W'(`PW_CLK_PERIOD_NS / `PW_UNIT_NS);

    // ****************************************************************
    // helpers
    // ****************************************************************
    // band minimum width
    function automatic logic [TIME_W-1:0] band_wmin(input logic [TIME_W-1:0] per);
        logic [TIME_W-1:0] w;
        if (per <= BAND1)
            w = WMIN1;
        else if (per <= BAND2)
            w = WMIN2;
        else if (per <= BAND3)
            w = WMIN3;
        else
            w = WMIN4;
        return w;
    endfunction

    // keeps a width inside [wmin, period - wmin]; the lower bound is the
    // duty floor, so clamping width also bounds the derived duty
    function automatic logic [TIME_W-1:0] clamp_width(input logic [TIME_W-1:0] w,
                                                      input logic [TIME_W-1:0] per);
        logic [TIME_W-1:0] lo;
        logic [TIME_W-1:0] hi;
        logic [TIME_W-1:0] r;
        lo = band_wmin(per);
        hi = per - lo;
        r  = w;
        if (w > hi)
            r = hi;
        else if (w < lo)
            r = lo;
        return r;
    endfunction

    // ****************************************************************
    // settings and update sequencer
    // ****************************************************************
    logic [TIME_W-1:0] period_ff;
    logic [TIME_W-1:0] nxt_period;
    logic [TIME_W-1:0] width_ff;
    logic [TIME_W-1:0] nxt_width;
    logic [DUTY_W-1:0] duty_ff;
    logic [DUTY_W-1:0] nxt_duty;
    logic              reject_ff;
    logic              nxt_reject;
    upd_state_e        state_ff;
    upd_state_e        nxt_state;

    logic              div_start;
    logic [PROD_W-1:0] div_dividend;
    logic [TIME_W-1:0] div_divisor;
    logic              div_done;
    logic [PROD_W-1:0] div_quotient;
    logic [TIME_W-1:0] new_width;

    // commands are taken only in idle; a duty write costs two divisions
    always_comb
    begin
        nxt_period   = period_ff;
        nxt_width    = width_ff;
        nxt_duty     = duty_ff;
        nxt_state    = state_ff;
        nxt_reject   = 1'b0;
        div_start    = 1'b0;
        div_dividend = '0;
        div_divisor  = period_ff;
        new_width    = width_ff;
        unique case (state_ff)
            ST_IDLE:
            begin
                if (i_cmd_valid)
                begin
                    unique case (i_cmd_sel)
                        SEL_PERIOD:
                        begin
                            if (i_cmd_value >= PERIOD_MIN && i_cmd_value <= PERIOD_MAX)
                            begin
                                new_width    = clamp_width(width_ff, i_cmd_value);
                                nxt_period   = i_cmd_value;
                                nxt_width    = new_width;
                                div_start    = 1'b1;
                                div_dividend = PROD_W'(new_width) * PROD_W'(DUTY_FULL);
                                div_divisor  = i_cmd_value;
                                nxt_state    = ST_DUTY_DIV;
                            end
                            else
                            begin
                                nxt_reject = 1'b1;
                            end
                        end
                        SEL_WIDTH:
                        begin
                            if (i_cmd_value >= WIDTH_MIN && i_cmd_value < PERIOD_MAX)
                            begin
                                new_width    = clamp_width(i_cmd_value, period_ff);
                                nxt_width    = new_width;
                                div_start    = 1'b1;
                                div_dividend = PROD_W'(new_width) * PROD_W'(DUTY_FULL);
                                nxt_state    = ST_DUTY_DIV;
                            end
                            else
                            begin
                                nxt_reject = 1'b1;
                            end
                        end
                        SEL_DUTY:
                        begin
                            if (i_cmd_value != '0 && i_cmd_value < TIME_W'(DUTY_FULL))
                            begin
                                div_start    = 1'b1;
                                div_dividend = PROD_W'(period_ff) * PROD_W'(i_cmd_value);
                                div_divisor  = TIME_W'(DUTY_FULL);
                                nxt_state    = ST_WIDTH_DIV;
                            end
                            else
                            begin
                                nxt_reject = 1'b1;
                            end
                        end
                        default:
                        begin
                            nxt_reject = 1'b1;
                        end
                    endcase
                end
            end
            ST_WIDTH_DIV:
            begin
                if (div_done)
                begin
                    new_width    = clamp_width(div_quotient[TIME_W-1:0], period_ff);
                    nxt_width    = new_width;
                    div_start    = 1'b1;
                    div_dividend = PROD_W'(new_width) * PROD_W'(DUTY_FULL);
                    nxt_state    = ST_DUTY_DIV;
                end
            end
            ST_DUTY_DIV:
            begin
                if (div_done)
                begin
                    nxt_duty  = div_quotient[DUTY_W-1:0];
                    nxt_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            period_ff <= PERIOD_DEF;
            width_ff  <= WIDTH_DEF;
            duty_ff   <= DUTY_DEF;
            reject_ff <= 1'b0;
            state_ff  <= ST_IDLE;
        end
        else
        begin
            period_ff <= nxt_period;
            width_ff  <= nxt_width;
            duty_ff   <= nxt_duty;
            reject_ff <= nxt_reject;
            state_ff  <= nxt_state;
        end
    end

    // shared divider for both directions of the width/duty conversion
    seq_divider
    #(
        .DIVIDEND_W (PROD_W),
        .DIVISOR_W  (TIME_W)
    )
    u_div
    (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_start    (div_start),
        .i_dividend (div_dividend),
        .i_divisor  (div_divisor),
        .o_done     (div_done),
        .o_quotient (div_quotient)
    );

    // ****************************************************************
    // waveform generator
    // ****************************************************************
    logic [TIME_W-1:0] phase_ff;
    logic [TIME_W-1:0] nxt_phase;
    logic              pulse_ff;
    logic              nxt_pulse;
    logic [TIME_W:0]   phase_sum;
    logic [TIME_W-1:0] min_width_ff;
    logic [TIME_W-1:0] nxt_min_width;

    // phase accumulates 50 ns per clock in 10 ns units and wraps at the period, so the
    // long-run period is exact even though edges sit on the clock grid
    always_comb
    begin
        phase_sum     = {1'b0, phase_ff} + {1'b0, STEP};
        nxt_min_width = band_wmin(period_ff);
        if (phase_ff >= period_ff)
            nxt_phase = '0;     // period shrank under the phase
        else if (phase_sum >= {1'b0, period_ff})
            nxt_phase = TIME_W'(phase_sum - {1'b0, period_ff});
        else
            nxt_phase = phase_sum[TIME_W-1:0];
        // high from rising to falling edge
        nxt_pulse = (phase_ff < width_ff);
    end

    // registers only
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            phase_ff     <= '0;
            pulse_ff     <= 1'b0;
            min_width_ff <= WMIN1;
        end
        else
        begin
            phase_ff     <= nxt_phase;
            pulse_ff     <= nxt_pulse;
            min_width_ff <= nxt_min_width;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign o_cmd_ready  = (state_ff == ST_IDLE);
    assign o_cmd_reject = reject_ff;
    assign o_period     = period_ff;
    assign o_width      = width_ff;
    assign o_duty       = duty_ff;
    assign o_min_width  = min_width_ff;
    assign o_pulse      = pulse_ff;

endmodule

// *** sim/pulse_waveform_timing_asserts.sv ***
`timescale 1ns/1ns

// ****************************************************************
// port checks for the pulse timing block
// ****************************************************************
module pulse_waveform_timing_chk
    import pulse_timing_pkg::*;
#(
    parameter int TIME_W = 38,
    parameter int DUTY_W = 14
)
(
    // clock and reset
    input wire logic              i_core_clk,
    input wire logic              i_rst_n,
    // command port
    input wire logic              i_cmd_valid,
    input wire logic [1:0]        i_cmd_sel,
    input wire logic [TIME_W-1:0] i_cmd_value,
    input wire logic              o_cmd_ready,
    input wire logic              o_cmd_reject,
    // settings and waveform
    input wire logic [TIME_W-1:0] o_period,
    input wire logic [TIME_W-1:0] o_width,
    input wire logic [DUTY_W-1:0] o_duty,
    input wire logic [TIME_W-1:0] o_min_width,
    input wire logic              o_pulse
);
    logic [7:0] low_cnt_ff;
    logic [7:0] nxt_low_cnt;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    // busy length; saturates so a stuck sequencer cannot wrap to a legal count
    always_comb
    begin
        nxt_low_cnt = o_cmd_ready ? 8'h00 : low_cnt_ff + {7'h00, low_cnt_ff != 8'hff};
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            low_cnt_ff <= 8'h00;
        else
            low_cnt_ff <= nxt_low_cnt;
    end

    // band minimum width in 10 ns steps
    function automatic logic [TIME_W-1:0] band_min(input logic [TIME_W-1:0] p);
        if (p <= 38'h3b9aca00)
            return 38'h4;
        if (p <= 38'h2540be400)
            return 38'h14;
        if (p <= 38'h174876e800)
            return 38'hc8;
        return 38'h7d0;
    endfunction

    sequence s_take;
        i_cmd_valid && o_cmd_ready;
    endsequence

    sequence s_refused;
        s_take ##1 o_cmd_reject;
    endsequence

    AST_REJ_CAUSE: assert property (
        o_cmd_reject |-> $past(i_cmd_valid && o_cmd_ready)) else $error("reject without request");
    AST_SEL_BAD: assert property (
        s_take ##0 i_cmd_sel == 2'h3 |=> o_cmd_reject) else $error("bad select not refused");
    AST_PERIOD_BAD: assert property (
        s_take ##0 (i_cmd_sel == 2'h0 && (i_cmd_value < 38'h14 || i_cmd_value > 38'h2e90edd000))
        |=> o_cmd_reject) else $error("period out of span not refused");
    AST_REFUSE_HOLD: assert property (
        s_refused |-> o_cmd_ready && $stable(o_period) && $stable(o_width))
        else $error("refused command changed settings");
    AST_ACCEPT_BUSY: assert property (
        s_take ##1 !o_cmd_reject |-> !o_cmd_ready) else $error("accepted command left ready high");
    AST_WIDTH_BOUND: assert property (
        o_cmd_ready |-> o_width >= o_min_width && o_width + o_min_width <= o_period)
        else $error("width outside period minus minimum");
    AST_MIN_BAND: assert property (
        o_cmd_ready |-> o_min_width == band_min(o_period)) else $error("minimum width off band");
    AST_DUTY_CALC: assert property (
        o_cmd_ready |-> 64'(o_duty) == (64'(o_width) * 64'h2710) / 64'(o_period))
        else $error("duty not width over period");
    AST_DUTY_RANGE: assert property (
        o_cmd_ready |-> o_duty < 14'h2710) else $error("duty reached full scale");
    AST_BUSY_LEN: assert property (
        $rose(o_cmd_ready) |-> low_cnt_ff == 8'h35 || low_cnt_ff == 8'h6a)
        else $error("update sequence length wrong");
endmodule

bind pulse_waveform_timing pulse_waveform_timing_chk #(.TIME_W(TIME_W), .DUTY_W(DUTY_W)) i_chk
(
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
    .i_cmd_sel(i_cmd_sel), .i_cmd_value(i_cmd_value), .o_cmd_ready(o_cmd_ready),
    .o_cmd_reject(o_cmd_reject), .o_period(o_period), .o_width(o_width), .o_duty(o_duty),
    .o_min_width(o_min_width), .o_pulse(o_pulse)
);

// *** sim/host_cmd_model.sv ***
`timescale 1ns/1ns

// ****************************************************************
// host side issuing pulse settings
// ****************************************************************
module host_cmd_model
(
    // clock
    input  wire logic i_core_clk,
    // handshake from the block
    input  wire logic i_cmd_ready,
    // request to the block
    output logic        o_cmd_valid,
    output logic [1:0]  o_cmd_sel,
    output logic [37:0] o_cmd_value
);
    initial
    begin
        o_cmd_valid = 1'b0;
        o_cmd_sel   = 2'h0;
        o_cmd_value = 38'h0;
    end

    // one command; idle cycles let the host be prompt or slow
    task automatic send(input logic [1:0] sel, input logic [37:0] value, input int idle,
                        output bit ok);
        int n;
        ok = 1'b0;
        repeat (idle + 1) @(negedge i_core_clk);
        o_cmd_valid = 1'b1;
        o_cmd_sel   = sel;
        o_cmd_value = value;
        // ready is settled at the falling edge, so the next rising edge takes it
        for (n = 0; n < 300 && !ok; n++)
        begin
            ok = (i_cmd_ready === 1'b1);
            @(negedge i_core_clk);
        end
        o_cmd_valid = 1'b0;
        // released lines show the inverse, never a stale copy
        o_cmd_sel   = ~sel;
        o_cmd_value = ~value;
    endtask
endmodule

// *** sim/test_pulse_waveform_timing.sv ***
`timescale 1ns/1ns

// ****************************************************************
// self-checking bench for the pulse timing block
// ****************************************************************
module test_pulse_waveform_timing
    import pulse_timing_pkg::*;
;
    logic        core_clk;
    logic        rst_n;
    logic        cmd_valid;
    logic [1:0]  cmd_sel;
    logic [37:0] cmd_value;
    logic        cmd_ready;
    logic        cmd_reject;
    logic [37:0] period;
    logic [37:0] width;
    logic [13:0] duty;
    logic [37:0] min_width;
    logic        pulse;
    int          fails;
    int          n_tests;

    pulse_waveform_timing i_dut
    (
        .i_core_clk(core_clk), .i_rst_n(rst_n), .i_cmd_valid(cmd_valid),
        .i_cmd_sel(cmd_sel), .i_cmd_value(cmd_value), .o_cmd_ready(cmd_ready),
        .o_cmd_reject(cmd_reject), .o_period(period), .o_width(width), .o_duty(duty),
        .o_min_width(min_width), .o_pulse(pulse)
    );

    host_cmd_model i_host
    (
        .i_core_clk(core_clk), .i_cmd_ready(cmd_ready), .o_cmd_valid(cmd_valid),
        .o_cmd_sel(cmd_sel), .o_cmd_value(cmd_value)
    );

    // 20 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk_time(input logic [37:0] act, input logic [37:0] exp, input string what);
        n_tests++;
        if (act !== exp)
        begin
            fails++;
            $display("[ERR] %0t %s got %0d expected %0d", $time, what, act, exp);
        end
    endtask

    task automatic chk_duty(input logic [13:0] act, input logic [13:0] exp);
        n_tests++;
        if (act !== exp)
        begin
            fails++;
            $display("[ERR] %0t duty got %0d expected %0d", $time, act, exp);
        end
    endtask

    task automatic chk_bit(input logic act, input logic exp, input string what);
        n_tests++;
        if (act !== exp)
        begin
            fails++;
            $display("[ERR] %0t %s got %b expected %b", $time, what, act, exp);
        end
    endtask

    task automatic hang(input string what);
        fails++;
        $display("[ERR] %0t wait for %s ran out", $time, what);
        final_report();
    endtask

    // send, check the refusal flag, then wait until the block is idle
    task automatic cmd(input logic [1:0] sel, input logic [37:0] value, input logic rej);
        bit ok;
        int n;
        i_host.send(sel, value, rej ? 0 : 2, ok);
        if (!ok)
            hang("ready");
        chk_bit(cmd_reject, rej, "reject");
        for (n = 0; n < 300 && cmd_ready !== 1'b1; n++)
            @(negedge core_clk);
        if (cmd_ready !== 1'b1)
            hang("update");
    endtask

    task automatic sc_defaults();
        chk_time(period, 38'h186a0, "period");
        chk_time(width, 38'hc350, "width");
        chk_duty(duty, 14'h1388);
        chk_time(min_width, 38'h4, "min width");
    endtask

    // every kind of out-of-range request plus the unused select
    task automatic sc_refusals();
        logic [1:0]  s [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
        logic [37:0] v [7] = '{38'h13, 38'h2e90edd001, 38'h3, 38'h2e90edd000, 38'h0,
                               38'h2710, 38'h64};
        for (int i = 0; i < 7; i++)
        begin
            cmd(s[i], v[i], 1'b1);
            chk_time(period, 38'h186a0, "period");
            chk_time(width, 38'hc350, "width");
        end
    endtask

    task automatic sc_period_min();
        cmd(2'h0, 38'h14, 1'b0);
        chk_time(period, 38'h14, "period");
        chk_time(width, 38'h10, "width");
        chk_duty(duty, 14'h1f40);
        chk_time(min_width, 38'h4, "min width");
    endtask

    task automatic sc_width_duty();
        cmd(2'h1, 38'h4, 1'b0);
        chk_duty(duty, 14'h7d0);
        cmd(2'h1, 38'h12, 1'b0);
        chk_time(width, 38'h10, "width");
        cmd(2'h0, 38'h64, 1'b0);
        chk_duty(duty, 14'h640);
        cmd(2'h2, 38'h1, 1'b0);
        chk_time(width, 38'h4, "width");
        chk_duty(duty, 14'h190);
        cmd(2'h2, 38'h270f, 1'b0);
        chk_duty(duty, 14'h2580);
        cmd(2'h2, 38'hfa0, 1'b0);
        chk_time(width, 38'h28, "width");
    endtask

    // period 1 us, width 400 ns: two periods hold sixteen high cycles
    task automatic sc_pulse();
        int high;
        high = 0;
        repeat (40)
        begin
            @(negedge core_clk);
            high += (pulse === 1'b1);
        end
        chk_time(38'(high), 38'h10, "high cycles");
    endtask

    task automatic sc_bands();
        logic [37:0] p [5] = '{38'h3b9aca00, 38'h3b9aca01, 38'h2540be401, 38'h174876e801,
                               38'h2e90edd000};
        logic [37:0] m [5] = '{38'h4, 38'h14, 38'hc8, 38'h7d0, 38'h7d0};
        logic [37:0] w [5] = '{38'h28, 38'h28, 38'hc8, 38'h7d0, 38'h7d0};
        for (int i = 0; i < 5; i++)
        begin
            cmd(2'h0, p[i], 1'b0);
            chk_time(min_width, m[i], "min width");
            chk_time(width, w[i], "width");
        end
    endtask

    initial
    begin
        fails   = 0;
        n_tests = 0;
        rst_n   = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        sc_defaults();
        sc_refusals();
        sc_period_min();
        sc_width_duty();
        sc_pulse();
        sc_bands();
        final_report();
    end
endmodule
